/* File: src/pgrs_pkg.sv */
// package: constants, types and timing for the power-good / reset sequencing pair
// Operation
// - board holds supply_ok low, then rises cleanly
// - supply_ok may drop; restabilise before rising
// - each supply_ok rise followed by 1-10 ms reset
// - supply_ok stays high during boundary scan
// - reset clears state, invalidates caches, no writeback
// - power-on reset held at least 1 ms
// - bus outputs released within two clocks of reset (the device releases them on the third clock)
// - reset never longer than 10 ms while supply_ok
// - straps captured at reset deassertion
// - sys_mgmt_irq_n low at release tristates outputs
package pgrs_pkg;
  localparam int unsigned CLK_HZ       = 20000000;
  localparam int unsigned RST_MIN_US   = 1000;   // least reset pulse
  localparam int unsigned RST_MAX_US   = 10000;  // longest reset pulse
  localparam int unsigned RST_PICK_US  = 2000;   // pulse the board actually gives
  localparam int unsigned STABLE_US    = 1000;   // supply settle before supply_ok
  // cycle counts: microseconds times whole clocks per microsecond, no rounding up for any
  localparam int unsigned RST_MIN_CYC  = (RST_MIN_US * (CLK_HZ / 1000000));
  localparam int unsigned RST_MAX_CYC  = (RST_MAX_US * (CLK_HZ / 1000000));
  localparam int unsigned RST_PICK_CYC = (RST_PICK_US * (CLK_HZ / 1000000));
  localparam int unsigned STABLE_CYC   = (STABLE_US * (CLK_HZ / 1000000));
  localparam int unsigned CNT_W        = 24;
  localparam int unsigned STRAP_W      = 8;
  localparam int unsigned BUS_W        = 8;
  localparam int unsigned REL_CYC      = 2;      // bus release deadline
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 24'h000001;
  localparam logic [STRAP_W-1:0] STRAP_RST = 8'h00;
  localparam logic [BUS_W-1:0]   BUS_IDLE  = 8'h00;
  localparam logic [1:0]         SYNC_LOW  = 2'h0;   // synchroniser stages behind a low pin
  localparam logic [1:0]         SYNC_HIGH = 2'h3;   // synchroniser stages behind a high pin

  typedef enum logic [1:0] {PGRS_OFF, PGRS_SETTLE, PGRS_RESET, PGRS_RUN} pgrs_board_t;
  typedef enum logic [1:0] {PGRS_DOWN, PGRS_INRESET, PGRS_ACTIVE, PGRS_FLOAT} pgrs_dev_t;
endpackage : pgrs_pkg

/* File: src/pgrs_link_if.sv */
// interface: power-good, reset, sys-mgmt interrupt and strap wires between board and device
`timescale 1ns/1ns
`default_nettype none
interface pgrs_link_if;
  logic                          supply_ok_in;   // board -> device
  logic                          reset_n;        // board -> device, active low
  logic                          sys_mgmt_irq_n; // board -> device, active low
  logic [pgrs_pkg::STRAP_W-1:0]  strap;          // board -> device, config levels
  modport board  (output supply_ok_in, output reset_n, output sys_mgmt_irq_n, output strap);
  modport device (input supply_ok_in, input reset_n, input sys_mgmt_irq_n, input strap);
endinterface : pgrs_link_if
`default_nettype wire

/* File: src/pgrs_board.sv */
// module: board-side power-good and reset pulse sequencer
`timescale 1ns/1ns
`default_nettype none
module pgrs_board #(
  parameter int unsigned STABLE_CYC = pgrs_pkg::STABLE_CYC,
  parameter int unsigned RST_CYC    = pgrs_pkg::RST_PICK_CYC
) (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  // user side
  input  wire logic                        supplies_stable,
  input  wire logic                        scan_active,
  input  wire logic                        smi_req,
  input  wire logic [pgrs_pkg::STRAP_W-1:0] strap_val,
  output logic                             seq_running,
  // link
  pgrs_link_if.board                       link
);
  pgrs_pkg::pgrs_board_t       state_reg, state_next;
  logic [pgrs_pkg::CNT_W-1:0]  cnt_reg, cnt_next;
  logic                        pg_reg, pg_next;
  logic                        rstn_reg, rstn_next;
  logic                        smi_n_reg, smi_n_next;
  logic [pgrs_pkg::STRAP_W-1:0] strap_reg, strap_next;
  logic                        run_reg, run_next;

  // true on the last cycle of a count of target cycles
  function automatic logic count_end(
    input logic [pgrs_pkg::CNT_W-1:0] cnt,
    input int unsigned                target
  );
    count_end = (cnt == target[pgrs_pkg::CNT_W-1:0] - pgrs_pkg::CNT_ONE);
  endfunction : count_end

  // supply_ok may only fall once supplies fail and no scan still needs it
  function automatic logic power_lost(
    input logic stable,
    input logic scan
  );
    power_lost = !stable && !scan;
  endfunction : power_lost

  // sequencer: settle, raise supply_ok, then a timed reset pulse
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    pg_next    = pg_reg;
    rstn_next  = rstn_reg;
    smi_n_next = ~smi_req;
    strap_next = strap_val;
    run_next   = 1'b0;
    case (state_reg)
      pgrs_pkg::PGRS_OFF:
      begin
        pg_next   = 1'b0;
        rstn_next = 1'b0;
        cnt_next  = pgrs_pkg::CNT_ZERO;
        if (supplies_stable)
          state_next = pgrs_pkg::PGRS_SETTLE;
      end
      pgrs_pkg::PGRS_SETTLE:
      begin
        // supplies must hold stable for the whole window before rising
        if (!supplies_stable)
          state_next = pgrs_pkg::PGRS_OFF;
        else if (count_end(cnt_reg, STABLE_CYC))
        begin
          pg_next    = 1'b1;
          cnt_next   = pgrs_pkg::CNT_ZERO;
          state_next = pgrs_pkg::PGRS_RESET;
        end
        else
          cnt_next = cnt_reg + pgrs_pkg::CNT_ONE;
      end
      pgrs_pkg::PGRS_RESET:
      begin
        rstn_next = 1'b0;
        if (power_lost(supplies_stable, scan_active))
          state_next = pgrs_pkg::PGRS_OFF;
        else if (count_end(cnt_reg, RST_CYC))
        begin
          rstn_next  = 1'b1;
          state_next = pgrs_pkg::PGRS_RUN;
        end
        else
          cnt_next = cnt_reg + pgrs_pkg::CNT_ONE;
      end
      pgrs_pkg::PGRS_RUN:
      begin
        run_next = 1'b1;
        // scan holds supply_ok high even if supplies wobble
        if (power_lost(supplies_stable, scan_active))
          state_next = pgrs_pkg::PGRS_OFF;
      end
      default:
        state_next = pgrs_pkg::PGRS_OFF;
    endcase
    if (state_next == pgrs_pkg::PGRS_OFF)
    begin
      pg_next   = 1'b0;
      rstn_next = 1'b0;
    end
  end

  // registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_reg <= pgrs_pkg::PGRS_OFF;
      cnt_reg   <= pgrs_pkg::CNT_ZERO;
      pg_reg    <= 1'b0;
      rstn_reg  <= 1'b0;
      smi_n_reg <= 1'b1;
      strap_reg <= pgrs_pkg::STRAP_RST;
      run_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      pg_reg    <= pg_next;
      rstn_reg  <= rstn_next;
      smi_n_reg <= smi_n_next;
      strap_reg <= strap_next;
      run_reg   <= run_next;
    end
  end

  assign link.supply_ok_in   = pg_reg;
  assign link.reset_n        = rstn_reg;
  assign link.sys_mgmt_irq_n = smi_n_reg;
  assign link.strap          = strap_reg;
  assign seq_running         = run_reg;
endmodule : pgrs_board
`default_nettype wire

/* File: src/pgrs_device.sv */
// module: device-side reset response, strap capture and output float control
`timescale 1ns/1ns
`default_nettype none
module pgrs_device (
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  // link
  pgrs_link_if.device                       link,
  // user side: core bus outputs
  input  wire logic [pgrs_pkg::BUS_W-1:0]   bus_out_req,
  input  wire logic [pgrs_pkg::BUS_W-1:0]   bus_oe_req,
  output logic      [pgrs_pkg::BUS_W-1:0]   bus_out,
  output logic      [pgrs_pkg::BUS_W-1:0]   bus_oe,
  // user side: state
  output logic                              core_reset,
  output logic                              cache_inval,
  output logic      [pgrs_pkg::STRAP_W-1:0] config_straps,
  output logic                              outputs_floated
);
  // synchroniser stages: bit 0 takes the pin, bit 1 is the only one read
  logic [1:0]                   pg_sync_reg, pg_sync_next;
  logic [1:0]                   rn_sync_reg, rn_sync_next;
  logic [1:0]                   smi_sync_reg, smi_sync_next;
  logic                         pg_s, rn_s, smi_s;
  // sequencing state and the strap word taken at release
  pgrs_pkg::pgrs_dev_t          state_reg, state_next;
  logic [pgrs_pkg::STRAP_W-1:0] strap_reg, strap_next;
  // output stage
  logic [pgrs_pkg::BUS_W-1:0]   out_reg, out_next;
  logic [pgrs_pkg::BUS_W-1:0]   oe_reg, oe_next;
  logic                         crst_reg, crst_next;
  logic                         inv_reg, inv_next;
  logic                         flt_reg, flt_next;
  logic                         core_drive;

  // one more stage for a pin: the pin enters at the bottom
  function automatic logic [1:0] sync_shift(
    input logic [1:0] stages,
    input logic       pin
  );
    sync_shift = {stages[0], pin};
  endfunction : sync_shift

  // bus word the core may show: its own request while driving, idle otherwise
  function automatic logic [pgrs_pkg::BUS_W-1:0] bus_word(
    input logic                       drive,
    input logic [pgrs_pkg::BUS_W-1:0] req
  );
    bus_word = drive ? req : pgrs_pkg::BUS_IDLE;
  endfunction : bus_word

  // power lost or reset held, both as seen behind the synchronisers
  function automatic logic reset_seen(
    input logic pg,
    input logic rn
  );
    reset_seen = !pg || !rn;
  endfunction : reset_seen

  // synchronisers: the board logic drives these pins with no timing relation to us
  always_comb
  begin
    pg_sync_next  = sync_shift(pg_sync_reg, link.supply_ok_in);
    rn_sync_next  = sync_shift(rn_sync_reg, link.reset_n);
    smi_sync_next = sync_shift(smi_sync_reg, link.sys_mgmt_irq_n);
  end

  // synchroniser flops; interrupt stages start high like the idle pin,
  // so no false interrupt is seen on the first release after reset
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pg_sync_reg  <= pgrs_pkg::SYNC_LOW;
      rn_sync_reg  <= pgrs_pkg::SYNC_LOW;
      smi_sync_reg <= pgrs_pkg::SYNC_HIGH;
    end
    else
    begin
      pg_sync_reg  <= pg_sync_next;
      rn_sync_reg  <= rn_sync_next;
      smi_sync_reg <= smi_sync_next;
    end
  end

  // second stage only is read; first stage feeds nothing else
  assign pg_s  = pg_sync_reg[1];
  assign rn_s  = rn_sync_reg[1];
  assign smi_s = smi_sync_reg[1];

  // sequencing: down until power good, in reset until release, then run or float
  always_comb
  begin
    state_next = state_reg;
    strap_next = strap_reg;
    case (state_reg)
      pgrs_pkg::PGRS_DOWN:
      begin
        if (pg_s)
          state_next = pgrs_pkg::PGRS_INRESET;
      end
      pgrs_pkg::PGRS_INRESET:
      begin
        // straps come straight off the link, not synchronised: the board
        // must hold them steady for a few cycles around the release
        if (rn_s)
        begin
          strap_next = link.strap;
          state_next = smi_s ? pgrs_pkg::PGRS_ACTIVE : pgrs_pkg::PGRS_FLOAT;
        end
      end
      pgrs_pkg::PGRS_ACTIVE,
      pgrs_pkg::PGRS_FLOAT:
      begin
        // float lasts until reset or power loss; the core cannot leave it
        state_next = state_reg;
      end
      default:
        state_next = pgrs_pkg::PGRS_DOWN;
    endcase
    // loss of power wins over reset, and both win over any running state
    if (reset_seen(pg_s, rn_s))
      state_next = pg_s ? pgrs_pkg::PGRS_INRESET : pgrs_pkg::PGRS_DOWN;
  end

  // sequencing registers; straps keep their last capture until the next release
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_reg <= pgrs_pkg::PGRS_DOWN;
      strap_reg <= pgrs_pkg::STRAP_RST;
    end
    else
    begin
      state_reg <= state_next;
      strap_reg <= strap_next;
    end
  end

  // output stage: the core reaches the bus only while running, and a reset
  // seen this cycle takes the bus back at the next edge whatever the state
  always_comb
  begin
    core_drive = 1'b0;
    crst_next  = 1'b1;
    inv_next   = 1'b0;
    flt_next   = flt_reg;
    case (state_reg)
      pgrs_pkg::PGRS_DOWN:
        flt_next = 1'b0;
      pgrs_pkg::PGRS_INRESET:
      begin
        inv_next = 1'b1;
        flt_next = 1'b0;
      end
      pgrs_pkg::PGRS_ACTIVE:
      begin
        crst_next  = 1'b0;
        core_drive = 1'b1;
      end
      pgrs_pkg::PGRS_FLOAT:
      begin
        crst_next = 1'b0;
        flt_next  = 1'b1;
      end
      default:
        flt_next = 1'b0;
    endcase
    // two sync edges plus this one: the bus is idle by the third pin edge
    if (reset_seen(pg_s, rn_s))
    begin
      crst_next  = 1'b1;
      core_drive = 1'b0;
    end
    out_next = bus_word(core_drive, bus_out_req);
    oe_next  = bus_word(core_drive, bus_oe_req);
  end

  // output registers: every user-side output but config_straps comes straight from here
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      out_reg  <= pgrs_pkg::BUS_IDLE;
      oe_reg   <= pgrs_pkg::BUS_IDLE;
      crst_reg <= 1'b1;
      inv_reg  <= 1'b0;
      flt_reg  <= 1'b0;
    end
    else
    begin
      out_reg  <= out_next;
      oe_reg   <= oe_next;
      crst_reg <= crst_next;
      inv_reg  <= inv_next;
      flt_reg  <= flt_next;
    end
  end

  assign bus_out         = out_reg;
  assign bus_oe          = oe_reg;
  assign core_reset      = crst_reg;
  assign cache_inval     = inv_reg;
  assign config_straps   = strap_reg;
  assign outputs_floated = flt_reg;
endmodule : pgrs_device
`default_nettype wire

/* File: sim/pgrs_link_checker.sv */
// checker: link and device response properties for the sequencing pair
`timescale 1ns/1ns
`default_nettype none
module pgrs_link_checker #(
  parameter int unsigned RST_CYC = 8
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // link
  input wire logic       supply_ok_in,
  input wire logic       reset_n,
  input wire logic       sys_mgmt_irq_n,
  input wire logic [7:0] strap,
  // user sides
  input wire logic       scan_active,
  input wire logic [7:0] bus_oe,
  input wire logic       core_reset,
  input wire logic       cache_inval,
  input wire logic [7:0] config_straps,
  input wire logic       outputs_floated
);
  logic [15:0] low_reg;
  logic [15:0] low_next;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // reset-low time under good power; one counter bounds the pulse both ways
  always_comb low_next = (supply_ok_in && !reset_n) ? low_reg + 16'h0001 : 16'h0000;
  always_ff @(posedge sys_clk) low_reg <= rst ? 16'h0000 : low_next;
  pg_low_hold_a: assert property (!supply_ok_in |-> !reset_n)
    else $error("reset released without power good");
  rst_max_a: assert property ({16'h0000, low_reg} <= RST_CYC)
    else $error("reset pulse too long");
  rst_min_a: assert property ($rose(reset_n) |-> {16'h0000, low_reg} >= RST_CYC)
    else $error("reset pulse too short");
  sync_delay_a: assert property ($rose(reset_n) |-> core_reset ##1 core_reset)
    else $error("reset release seen unsynchronised");
  bus_release_a: assert property ($fell(reset_n) |-> ##[1:3] (bus_oe == 8'h00))
    else $error("bus not released after reset");
  inval_in_reset_a: assert property (cache_inval |-> core_reset)
    else $error("invalidate outside reset");
  strap_capture_a: assert property ($rose(reset_n) |-> ##[2:4] (!core_reset && config_straps == strap))
    else $error("straps not captured at release");
  float_on_irq_a: assert property ($rose(reset_n) && !sys_mgmt_irq_n |-> ##[2:4] outputs_floated)
    else $error("outputs not floated");
  scan_hold_a: assert property (scan_active && supply_ok_in |=> supply_ok_in)
    else $error("power good dropped in scan");
  cover property ($rose(reset_n) && !sys_mgmt_irq_n);
  cover property ($fell(supply_ok_in));
  cover property (scan_active && supply_ok_in);
  cover property ($rose(reset_n) && sys_mgmt_irq_n);
endmodule : pgrs_link_checker
`default_nettype wire

/* File: sim/tb_power_good_reset_sequencing.sv */
// testbench: board and device joined over the link, checked against a small model
`timescale 1ns/1ns
`default_nettype none
module tb_power_good_reset_sequencing;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       supplies_stable = 1'b0, scan_active = 1'b0, smi_req = 1'b0;
  logic [7:0] strap_val = 8'h00, bus_out_req = 8'h00, bus_oe_req = 8'h00;
  logic [7:0] bus_out, bus_oe, config_straps;
  logic       seq_running, core_reset, cache_inval, outputs_floated;
  int         mismatches = 0, total_checks = 0, n, seed = 32'h707ad8cf;
  logic [7:0] exp_q[$];
  localparam int unsigned STABLE = 4;  // short settle for simulation
  localparam int unsigned RSTC   = 8;  // short reset pulse for simulation
  pgrs_link_if link_if();
  pgrs_board #(.STABLE_CYC(STABLE), .RST_CYC(RSTC)) pgrs_board_i (.sys_clk, .rst,
    .supplies_stable, .scan_active, .smi_req, .strap_val, .seq_running, .link(link_if));
  pgrs_device pgrs_device_i (.sys_clk, .rst, .link(link_if), .bus_out_req, .bus_oe_req,
    .bus_out, .bus_oe, .core_reset, .cache_inval, .config_straps, .outputs_floated);
  pgrs_link_checker #(.RST_CYC(RSTC)) pgrs_link_checker_i (.sys_clk, .rst,
    .supply_ok_in(link_if.supply_ok_in), .reset_n(link_if.reset_n),
    .sys_mgmt_irq_n(link_if.sys_mgmt_irq_n), .strap(link_if.strap), .scan_active,
    .bus_oe, .core_reset, .cache_inval, .config_straps, .outputs_floated);
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end
  // inputs move 5 ns after the edge so the edge never races the bench
  task automatic step();
    @(posedge sys_clk);
    #5;
  endtask : step
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // bounded wait on a link level; running out ends the run as a failure
  task automatic wait_link(input bit rline, input logic lvl);
    for (n = 0; n < 100 && (rline ? link_if.reset_n : link_if.supply_ok_in) !== lvl; n++)
      step();
    if (n == 100)
    begin
      mismatches++;
      $display("ERROR wait_link expected %b seen %b", lvl, ~lvl);
      complete_run();
    end
  endtask : wait_link
  // passes cycle through irq at release and a scan hold during power loss
  initial
  begin
    repeat (10) step();
    rst = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      smi_req = i[0];
      strap_val = 8'($random(seed));
      bus_oe_req = 8'($random(seed));
      bus_out_req = 8'($random(seed));
      exp_q.push_back(strap_val);
      // a one-cycle supply dip in mid settle must restart the settle count
      supplies_stable = 1'b1;
      repeat (2) step();
      supplies_stable = 1'b0;
      step();
      supplies_stable = 1'b1;
      wait_link(1'b0, 1'b1);
      check("settle_restart", 8'(n), 8'(STABLE + 1));
      repeat (4) step();
      check("cache_inval", {7'h00, cache_inval}, 8'h01);
      check("bus_oe_in_reset", bus_oe, 8'h00);
      wait_link(1'b1, 1'b1);
      check("reset_len", 8'(n + 4), 8'(RSTC));
      repeat (4) step();
      check("straps", config_straps, exp_q.pop_front());
      check("floated", {7'h00, outputs_floated}, {7'h00, i[0]});
      check("bus_oe", bus_oe, i[0] ? 8'h00 : bus_oe_req);
      check("core_reset", {7'h00, core_reset}, 8'h00);
      check("bus_out", bus_out, i[0] ? 8'h00 : bus_out_req);
      check("seq_running", {7'h00, seq_running}, 8'h01);
      // power loss, held off by a scan on the later passes
      bus_oe_req = 8'hff;
      bus_out_req = 8'hff;
      scan_active = i[1];
      supplies_stable = 1'b0;
      repeat (6) step();
      check("scan_hold", {7'h00, link_if.supply_ok_in}, {7'h00, i[1]});
      scan_active = 1'b0;
      smi_req = 1'b0;
      wait_link(1'b1, 1'b0);
      repeat (3) step();
      check("bus_released", bus_oe, 8'h00);
      check("core_reset", {7'h00, core_reset}, 8'h01);
      check("bus_out_released", bus_out, 8'h00);
      check("seq_stopped", {7'h00, seq_running}, 8'h00);
      $display("pass %0d done", i);
    end
    complete_run();
  end
endmodule : tb_power_good_reset_sequencing
`default_nettype wire
